// [src/i2c_reg_device.sv]
/*
 I2C slave holding the addressed register space: data window, window
 length, status, slave address, clock limit, optional timing words,
 restart trigger and speed selection.
 Assumes the link lines are asynchronous and sampled here; user status
 inputs come from logic on clk_i.
*/
`timescale 1ns/1ps
`include "i2c_reg_map.svh"

// Behaviour
// - Data window carries frames, limited by length
// - Window length two bytes, 0x0010 to 0xffff; this code caps it at 0x0020
// - New length applies from next transaction
// - Unsupported length loads largest supported length
// - Master reads length back after writing
// - Packet size equals window length minus five
// - Status word: flags high byte, length low
// - Bit31 busy, bit30 response ready
// - Bits 27..24 report supported features
// - Address write-only, resets to 0x20
// - New address applies from next transaction
// - Bits 6:0 address, bit15 makes persistent
// - Clock limit in kHz follows speed
// - Timing words all ones: unsupported
// - Any restart write resets the device
// - Speed codes 001, 010, 011, 100
// - Undefined speed codes are ignored
// - Speed bit15 persists, reads as zero
module i2c_reg_device (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	i2c_link_if.device link,
	input wire logic busy_i,
	input wire logic resp_ready_i,
	input wire logic [15:0] resp_len_i,
	output logic [6:0] slave_addr_o,
	output logic [2:0] speed_mode_o,
	output logic [15:0] window_len_o,
	output logic [15:0] max_packet_o,
	output logic frame_written_o,
	output logic restart_o
);
	import i2c_link_pkg::*;

	logic [1:0] scl_s, sda_s;
	logic scl_q, sda_q;
	logic rise, fall, start, stop;
	dev_state_t state_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] shift_r, tx_r, ptr_r, tx_byte, win_byte;
	logic rw_r, have_ptr_r, sda_oe_r;
	logic [15:0] byte_idx_r;
	logic [31:0] wr_buf_r, rd_word, sh_word, max_khz;
	logic [2:0] wr_cnt_r, rd_size;
	logic [4:0] sh;
	logic commit, wr_evt;
	logic [6:0] slave_addr_r, addr_pend_r, persist_addr_r;
	logic [15:0] window_len_r, len_pend_r, max_packet_r, wlen;
	logic [2:0] speed_r, persist_speed_r, wspeed;
	logic soft_rst_r, frame_r;
	logic [7:0] mem [0:(1 << `WINDOW_AW) - 1];

	//----------------------------------------------------------------
	// Line sampling
	//----------------------------------------------------------------
	// Two-stage synchronisers plus one history stage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scl_s <= 2'h3;
			sda_s <= 2'h3;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else if (ce_i) begin
			scl_s <= {scl_s[0], link.scl};
			sda_s <= {sda_s[0], link.sda};
			scl_q <= scl_s[1];
			sda_q <= sda_s[1];
		end
	end

	// Edges and bus conditions
	assign rise = scl_s[1] & ~scl_q;
	assign fall = ~scl_s[1] & scl_q;
	assign start = scl_s[1] & scl_q & sda_q & ~sda_s[1];
	assign stop = scl_s[1] & scl_q & ~sda_q & sda_s[1];

	//----------------------------------------------------------------
	// Read path
	//----------------------------------------------------------------
	// Clock limit for the selected speed
	always_comb begin
		case (speed_r)
			`SPEED_SM: max_khz = `KHZ_SM;
			`SPEED_FMP: max_khz = `KHZ_FMP;
			default: max_khz = `KHZ_FM;
		endcase
	end

	// Register word and its byte count, sent MSB first
	always_comb begin
		rd_word = 32'h0;
		rd_size = 3'h0;
		case (ptr_r)
			`REG_WINDOW_LEN: begin
				rd_word = {16'h0, len_pend_r};
				rd_size = 3'h2;
			end
			`REG_LINK_STATUS: begin
				rd_word = {busy_i, resp_ready_i, 2'h0, `FEATURES, 8'h0,
					resp_len_i};
				rd_size = 3'h4;
			end
			`REG_MAX_CLOCK: begin
				rd_word = max_khz;
				rd_size = 3'h4;
			end
			`REG_SPACING, `REG_RETRANSMIT: begin
				rd_word = `UNSUPPORTED;
				rd_size = 3'h4;
			end
			`REG_SPEED: begin
				rd_word = {29'h0, speed_r};
				rd_size = 3'h2;
			end
			default: rd_size = 3'h0;
		endcase
	end

	// Byte select; write-only and past-end bytes read as ff
	assign sh = {rd_size[1:0] - 2'h1 - byte_idx_r[1:0], 3'h0};
	assign sh_word = rd_word >> sh;
	assign win_byte = (byte_idx_r < window_len_r) ?
		mem[byte_idx_r[`WINDOW_AW-1:0]] : 8'hff;
	assign tx_byte = (ptr_r == `REG_DATA_WINDOW) ? win_byte :
		(byte_idx_r < {13'h0, rd_size}) ? sh_word[7:0] : 8'hff;

	//----------------------------------------------------------------
	// Protocol engine
	//----------------------------------------------------------------
	// Byte framing, acknowledge and read shifting
	always_ff @(posedge clk_i) begin
		if (rst_i || soft_rst_r) begin
			state_r <= D_IDLE;
			bit_cnt_r <= 4'h0;
			shift_r <= 8'h0;
			tx_r <= 8'h0;
			ptr_r <= 8'h0;
			rw_r <= 1'b0;
			have_ptr_r <= 1'b0;
			sda_oe_r <= 1'b0;
			byte_idx_r <= 16'h0;
			wr_buf_r <= 32'h0;
			wr_cnt_r <= 3'h0;
		end else if (ce_i) begin
			if (start) begin
				state_r <= D_ADDR;
				bit_cnt_r <= 4'h0;
				have_ptr_r <= 1'b0;
				byte_idx_r <= 16'h0;
				wr_cnt_r <= 3'h0;
				sda_oe_r <= 1'b0;
			end else if (stop) begin
				state_r <= D_IDLE;
				have_ptr_r <= 1'b0;
				sda_oe_r <= 1'b0;
			end else if (rise && state_r != D_IDLE) begin
				shift_r <= {shift_r[6:0], sda_s[1]};
				bit_cnt_r <= bit_cnt_r + 4'h1;
			end else if (fall) begin
				case (state_r)
					D_ADDR: if (bit_cnt_r == 4'h8) begin
						if (shift_r[7:1] == slave_addr_r) begin
							sda_oe_r <= 1'b1;
							rw_r <= shift_r[0];
							state_r <= D_ADDR_ACK;
						end else begin
							state_r <= D_IDLE;
						end
					end
					D_ADDR_ACK: begin
						bit_cnt_r <= 4'h0;
						if (rw_r) begin
							tx_r <= tx_byte;
							sda_oe_r <= ~tx_byte[7];
							state_r <= D_RD;
						end else begin
							sda_oe_r <= 1'b0;
							state_r <= D_WR;
						end
					end
					D_WR: if (bit_cnt_r == 4'h8) begin
						sda_oe_r <= 1'b1;
						state_r <= D_WR_ACK;
						if (!have_ptr_r) begin
							ptr_r <= shift_r;
							have_ptr_r <= 1'b1;
						end else begin
							wr_buf_r <= {wr_buf_r[23:0], shift_r};
							byte_idx_r <= byte_idx_r + 16'h1;
							if (wr_cnt_r != 3'h4)
								wr_cnt_r <= wr_cnt_r + 3'h1;
						end
					end
					D_WR_ACK: begin
						sda_oe_r <= 1'b0;
						bit_cnt_r <= 4'h0;
						state_r <= D_WR;
					end
					D_RD: if (bit_cnt_r == 4'h8) begin
						sda_oe_r <= 1'b0;
						byte_idx_r <= byte_idx_r + 16'h1;
						state_r <= D_RD_ACK;
					end else begin
						sda_oe_r <= ~tx_r[3'h7 - bit_cnt_r[2:0]];
					end
					D_RD_ACK: if (shift_r[0]) begin
						state_r <= D_IDLE;
					end else begin
						tx_r <= tx_byte;
						sda_oe_r <= ~tx_byte[7];
						bit_cnt_r <= 4'h0;
						state_r <= D_RD;
					end
					default: ;
				endcase
			end
		end
	end

	// Write events
	assign commit = ce_i & stop & have_ptr_r & ~rw_r & (wr_cnt_r != 3'h0);
	assign wr_evt = ce_i & fall & (state_r == D_WR) & (bit_cnt_r == 4'h8) &
		have_ptr_r & (ptr_r == `REG_DATA_WINDOW) &
		(byte_idx_r < window_len_r);

	// Data window storage
	always_ff @(posedge clk_i) begin
		if (wr_evt)
			mem[byte_idx_r[`WINDOW_AW-1:0]] <= shift_r;
	end

	//----------------------------------------------------------------
	// Configuration registers
	//----------------------------------------------------------------
	// Length of the last write (out-of-range values give the maximum) and its raw speed code
	assign wlen = (wr_buf_r[15:0] < `WINDOW_MIN ||
		wr_buf_r[15:0] > `WINDOW_MAX) ? `WINDOW_MAX : wr_buf_r[15:0];
	assign wspeed = wr_buf_r[2:0];

	// Persistent settings survive the restart trigger
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			persist_addr_r <= `SLAVE_ADDR_RST;
			persist_speed_r <= `SPEED_RST;
		end else if (commit && wr_buf_r[`PERSIST_BIT]) begin
			if (ptr_r == `REG_SLAVE_ADDR)
				persist_addr_r <= wr_buf_r[6:0];
			if (ptr_r == `REG_SPEED && wspeed >= `SPEED_SM &&
				wspeed <= `SPEED_FMP)
				persist_speed_r <= wspeed;
		end
	end

	// Volatile settings; pending values go live at a start
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			addr_pend_r <= `SLAVE_ADDR_RST;
			slave_addr_r <= `SLAVE_ADDR_RST;
			speed_r <= `SPEED_RST;
			len_pend_r <= `WINDOW_MAX;
			window_len_r <= `WINDOW_MAX;
		end else if (soft_rst_r) begin
			addr_pend_r <= persist_addr_r;
			slave_addr_r <= persist_addr_r;
			speed_r <= persist_speed_r;
			len_pend_r <= `WINDOW_MAX;
			window_len_r <= `WINDOW_MAX;
		end else if (ce_i) begin
			if (start) begin
				slave_addr_r <= addr_pend_r;
				window_len_r <= len_pend_r;
			end
			if (commit) begin
				case (ptr_r)
					`REG_WINDOW_LEN: len_pend_r <= wlen;
					`REG_SLAVE_ADDR: addr_pend_r <= wr_buf_r[6:0];
					`REG_SPEED: if (wspeed >= `SPEED_SM &&
						wspeed <= `SPEED_FMP)
						speed_r <= wspeed;
					default: ;
				endcase
			end
		end
	end

	// Restart pulse, frame notice and packet size
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			soft_rst_r <= 1'b0;
			frame_r <= 1'b0;
			max_packet_r <= `WINDOW_MAX - `PACKET_OVERHEAD;
		end else if (ce_i) begin
			soft_rst_r <= commit && ptr_r == `REG_RESTART;
			frame_r <= commit && ptr_r == `REG_DATA_WINDOW;
			max_packet_r <= window_len_r - `PACKET_OVERHEAD;
		end
	end

	//----------------------------------------------------------------
	// Outputs
	//----------------------------------------------------------------
	assign link.dev_scl_o = 1'b0;
	assign link.dev_scl_oe = 1'b0;
	assign link.dev_sda_o = 1'b0;
	assign link.dev_sda_oe = sda_oe_r;
	assign slave_addr_o = slave_addr_r;
	assign speed_mode_o = speed_r;
	assign window_len_o = window_len_r;
	assign max_packet_o = max_packet_r;
	assign frame_written_o = frame_r;
	assign restart_o = soft_rst_r;

endmodule // i2c_reg_device

// [common/i2c_reg_map.svh]
/*
 Offsets, field positions, reset values and timing counts of the
 register-mapped I2C slave and of its bus master.
 Assumes inclusion by bare name from both ends.
*/
`ifndef I2C_REG_MAP_SVH
`define I2C_REG_MAP_SVH

// Device register pointers
`define REG_DATA_WINDOW 8'h80
`define REG_WINDOW_LEN 8'h81
`define REG_LINK_STATUS 8'h82
`define REG_SLAVE_ADDR 8'h83
`define REG_MAX_CLOCK 8'h84
`define REG_SPACING 8'h85
`define REG_RETRANSMIT 8'h86
`define REG_RESTART 8'h88
`define REG_SPEED 8'h89

// Reset values and field positions
`define SLAVE_ADDR_RST 7'h20
`define SPEED_RST 3'h3
`define PERSIST_BIT 15
`define WINDOW_MIN 16'h0010
`define WINDOW_MAX 16'h0020
`define WINDOW_AW 5
`define PACKET_OVERHEAD 16'h0005
`define FEATURES 4'he
`define UNSUPPORTED 32'hffffffff

// Speed codes and matching clock limits in kHz
`define SPEED_SM 3'h1
`define SPEED_FM 3'h2
`define SPEED_SMFM 3'h3
`define SPEED_FMP 3'h4
`define KHZ_SM 32'h00000064
`define KHZ_FM 32'h00000190
`define KHZ_FMP 32'h000003e8

// Master timing: bus clock made by dividing the system clock
`define CLK_KHZ 20000
`define SCL_KHZ 1000
`define QTR_CYC ((`CLK_KHZ) / (4 * (`SCL_KHZ)))

// Master Wishbone word indices (byte address bits 4:2)
`define HREG_CTRL 3'h0
`define HREG_TARGET 3'h1
`define HREG_TX 3'h2
`define HREG_RX 3'h3
`define HREG_IRQ_STAT 3'h4
`define HREG_IRQ_MASK 3'h5

`endif

// [common/i2c_link_pkg.sv]
/*
 State types of both ends of the I2C register link.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package i2c_link_pkg;
	typedef enum logic [2:0] {D_IDLE, D_ADDR, D_ADDR_ACK, D_WR, D_WR_ACK,
		D_RD, D_RD_ACK} dev_state_t;
	typedef enum logic [2:0] {H_IDLE, H_START, H_TX, H_RX,
		H_STOP} host_state_t;
	typedef enum logic [2:0] {ST_ADDR_W, ST_PTR, ST_DATA, ST_ADDR_R,
		ST_RDATA} host_step_t;
endpackage

// [common/i2c_link_if.sv]
/*
 Two-wire open-drain link between master and slave.
 Assumes pull-ups: a line is low while any enabled driver drives low.
*/
`timescale 1ns/1ps
interface i2c_link_if;
	logic host_scl_o, host_scl_oe, host_sda_o, host_sda_oe;
	logic dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe;
	logic scl, sda;

	// Wired-and resolution of both lines
	assign scl = !((host_scl_oe && !host_scl_o) || (dev_scl_oe && !dev_scl_o));
	assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

	modport device (input scl, input sda, output dev_scl_o,
		output dev_scl_oe, output dev_sda_o, output dev_sda_oe);
	modport host (input scl, input sda, output host_scl_o,
		output host_scl_oe, output host_sda_o, output host_sda_oe);
endinterface

// [src/i2c_reg_host.sv]
/*
 I2C master that selects a slave register and writes or reads up to
 four bytes, ordered over classic Wishbone, with a masked interrupt.
 Assumes a slave without clock stretching; SDA arrives asynchronously.
*/
`timescale 1ns/1ps
`include "i2c_reg_map.svh"

module i2c_reg_host (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	i2c_link_if.host link,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq_o
);
	import i2c_link_pkg::*;

	localparam int QTR = `QTR_CYC;

	logic [1:0] sda_s;
	logic ack_r, acc_w, go, done_evt, nack_evt;
	logic [31:0] rdata_r, tx_data_r, rx_data_r, tx_sh_r;
	logic read_r;
	logic [2:0] count_r, left_r;
	logic [6:0] addr_r;
	logic [7:0] ptr_r, byte_r;
	logic [1:0] irq_stat_r, irq_mask_r;
	host_state_t state_r;
	host_step_t step_r;
	logic [7:0] qcnt_r;
	logic tick;
	logic [1:0] phase_r;
	logic [3:0] bit_r;
	logic scl_oe_r, sda_oe_r, ack_bit_r, restart_r;

	// Byte-lane merge for Wishbone writes
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		return (old & ~m) | (nw & m);
	endfunction

	//----------------------------------------------------------------
	// Wishbone slave
	//----------------------------------------------------------------
	// One wait state; read data registered with the ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			rdata_r <= 32'h0;
		end else if (ce_i) begin
			ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
			case (wb_adr_i[4:2])
				`HREG_CTRL: rdata_r <= {22'h0, rx_data_r == `UNSUPPORTED,
					state_r != H_IDLE, 3'h0, count_r, read_r, 1'b0};
				`HREG_TARGET: rdata_r <= {16'h0, ptr_r, 1'b0, addr_r};
				`HREG_TX: rdata_r <= tx_data_r;
				`HREG_RX: rdata_r <= rx_data_r;
				`HREG_IRQ_STAT: rdata_r <= {30'h0, irq_stat_r};
				`HREG_IRQ_MASK: rdata_r <= {30'h0, irq_mask_r};
				default: rdata_r <= 32'h0;
			endcase
		end
	end

	// Writes take effect at the edge that sees ack
	assign acc_w = ce_i & wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
	assign go = acc_w & (wb_adr_i[4:2] == `HREG_CTRL) & wb_sel_i[0] &
		wb_dat_i[0] & (state_r == H_IDLE);

	// Command registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			read_r <= 1'b0;
			count_r <= 3'h0;
			addr_r <= `SLAVE_ADDR_RST;
			ptr_r <= 8'h0;
			tx_data_r <= 32'h0;
			irq_mask_r <= 2'h0;
		end else if (acc_w) begin
			case (wb_adr_i[4:2])
				`HREG_CTRL: if (wb_sel_i[0]) begin
					read_r <= wb_dat_i[1];
					count_r <= wb_dat_i[4:2];
				end
				`HREG_TARGET: begin
					if (wb_sel_i[0])
						addr_r <= wb_dat_i[6:0];
					if (wb_sel_i[1])
						ptr_r <= wb_dat_i[15:8];
				end
				`HREG_TX: tx_data_r <= merge(tx_data_r, wb_dat_i, wb_sel_i);
				`HREG_IRQ_MASK: if (wb_sel_i[0])
					irq_mask_r <= wb_dat_i[1:0];
				default: ;
			endcase
		end
	end

	// Sticky events, write one to clear, set wins
	always_ff @(posedge clk_i) begin
		if (rst_i)
			irq_stat_r <= 2'h0;
		else if (ce_i)
			irq_stat_r <= (irq_stat_r & ~((acc_w && wb_sel_i[0] &&
				wb_adr_i[4:2] == `HREG_IRQ_STAT) ? wb_dat_i[1:0] : 2'h0))
				| {nack_evt, done_evt};
	end

	//----------------------------------------------------------------
	// Bit sequencer
	//----------------------------------------------------------------
	// SDA synchroniser
	always_ff @(posedge clk_i) begin
		if (rst_i)
			sda_s <= 2'h3;
		else if (ce_i)
			sda_s <= {sda_s[0], link.sda};
	end

	// Quarter-period divider
	always_ff @(posedge clk_i) begin
		if (rst_i || state_r == H_IDLE)
			qcnt_r <= 8'h0;
		else if (ce_i)
			qcnt_r <= tick ? 8'h0 : qcnt_r + 8'h1;
	end
	assign tick = ce_i && qcnt_r == 8'(QTR - 1);

	// Transfer end and nack events
	assign done_evt = tick && state_r == H_STOP && phase_r == 2'h3 &&
		!restart_r;
	assign nack_evt = tick && state_r == H_TX && phase_r == 2'h3 &&
		bit_r == 4'h8 && ack_bit_r;

	// Start, bytes with acknowledge, stop
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= H_IDLE;
			step_r <= ST_ADDR_W;
			phase_r <= 2'h0;
			bit_r <= 4'h0;
			byte_r <= 8'h0;
			left_r <= 3'h0;
			tx_sh_r <= 32'h0;
			rx_data_r <= 32'h0;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
			ack_bit_r <= 1'b0;
			restart_r <= 1'b0;
		end else if (go) begin
			state_r <= H_START;
			step_r <= ST_ADDR_W;
			phase_r <= 2'h0;
			tx_sh_r <= tx_data_r;
			rx_data_r <= 32'h0;
			restart_r <= 1'b0;
		end else if (tick) begin
			phase_r <= phase_r + 2'h1;
			case (state_r)
				H_START: case (phase_r)
					2'h0: begin
						sda_oe_r <= 1'b0;
						scl_oe_r <= 1'b0;
					end
					2'h1: sda_oe_r <= 1'b1;
					2'h2: scl_oe_r <= 1'b1;
					default: begin
						bit_r <= 4'h0;
						byte_r <= {addr_r, step_r == ST_ADDR_R};
						state_r <= H_TX;
					end
				endcase
				H_TX, H_RX: case (phase_r)
					2'h0: if (state_r == H_TX)
						sda_oe_r <= bit_r != 4'h8 && !byte_r[7];
					else
						sda_oe_r <= bit_r == 4'h8 && left_r != 3'h1;
					2'h1: scl_oe_r <= 1'b0;
					2'h2: if (bit_r == 4'h8)
						ack_bit_r <= sda_s[1];
					else if (state_r == H_RX)
						byte_r <= {byte_r[6:0], sda_s[1]};
					default: begin
						scl_oe_r <= 1'b1;
						bit_r <= bit_r + 4'h1;
						if (state_r == H_TX && bit_r != 4'h8)
							byte_r <= {byte_r[6:0], 1'b0};
						if (bit_r == 4'h8) begin
							bit_r <= 4'h0;
							if (state_r == H_RX) begin
								rx_data_r <= {rx_data_r[23:0], byte_r};
								left_r <= left_r - 3'h1;
								if (left_r == 3'h1)
									state_r <= H_STOP;
							end else if (ack_bit_r) begin
								state_r <= H_STOP;
								restart_r <= 1'b0;
							end else begin
								case (step_r)
									ST_ADDR_W: begin
										step_r <= ST_PTR;
										byte_r <= ptr_r;
									end
									ST_PTR: if (read_r) begin
										restart_r <= 1'b1;
										state_r <= H_STOP;
									end else if (count_r == 3'h0) begin
										state_r <= H_STOP;
									end else begin
										step_r <= ST_DATA;
										left_r <= count_r;
										byte_r <= tx_sh_r[31:24];
										tx_sh_r <= {tx_sh_r[23:0], 8'h0};
									end
									ST_DATA: begin
										left_r <= left_r - 3'h1;
										byte_r <= tx_sh_r[31:24];
										tx_sh_r <= {tx_sh_r[23:0], 8'h0};
										if (left_r == 3'h1)
											state_r <= H_STOP;
									end
									default: begin
										step_r <= ST_RDATA;
										left_r <= (count_r == 3'h0) ? 3'h1 :
											count_r;
										state_r <= H_RX;
									end
								endcase
							end
						end
					end
				endcase
				H_STOP: case (phase_r)
					2'h0: sda_oe_r <= 1'b1;
					2'h1: scl_oe_r <= 1'b0;
					2'h2: sda_oe_r <= 1'b0;
					default: if (restart_r) begin
						restart_r <= 1'b0;
						step_r <= ST_ADDR_R;
						state_r <= H_START;
					end else begin
						state_r <= H_IDLE;
					end
				endcase
				default: phase_r <= 2'h0;
			endcase
		end
	end

	//----------------------------------------------------------------
	// Outputs
	//----------------------------------------------------------------
	assign link.host_scl_o = 1'b0;
	assign link.host_scl_oe = scl_oe_r;
	assign link.host_sda_o = 1'b0;
	assign link.host_sda_oe = sda_oe_r;
	assign wb_dat_o = rdata_r;
	assign wb_ack_o = ack_r;
	assign irq_o = |(irq_stat_r & irq_mask_r);

endmodule // i2c_reg_host

// [test/i2c_link_props.sv]
/*
 Checker of the two-wire link between master and slave.
 Assumes the interface signals are fed in unchanged, one clock domain.
*/
`timescale 1ns/1ps
module i2c_link_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic host_scl_o,
	input wire logic host_scl_oe,
	input wire logic host_sda_o,
	input wire logic host_sda_oe,
	input wire logic dev_scl_o,
	input wire logic dev_scl_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	// ------------------------------
	// Link properties
	// ------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	open_drain_a: assert property (!(host_scl_o || host_sda_o ||
		dev_scl_o || dev_sda_o)) else $error("line driven high");
	no_stretch_a: assert property (!dev_scl_oe)
		else $error("slave holds clock");
	scl_owner_a: assert property (scl == !host_scl_oe)
		else $error("clock level wrong");
	scl_high_a: assert property ($rose(scl) |=> scl [*8])
		else $error("clock high too short");
	scl_low_a: assert property ($fell(scl) |=> !scl [*4])
		else $error("clock low too short");
	dev_turn_a: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("slave data moved in clock high");
	start_owner_a: assert property ($fell(sda) && scl && $past(scl)
		|-> host_sda_oe) else $error("start not by master");
	reset_idle_a: assert property ($fell(rst_i) |-> scl && sda
		&& !dev_sda_oe) else $error("lines busy after reset");
endmodule // i2c_link_props

// [test/testbench.sv]
/*
 Bench: master and slave joined by the link, driven over Wishbone.
 Assumes the shared register map header.
*/
`timescale 1ns/1ps
`include "i2c_reg_map.svh"
module testbench;
	logic clk_i, rst_i, busy_i, resp_ready_i, wb_cyc_i, wb_stb_i, wb_we_i;
	logic wb_ack_o, irq_o, frame_written_o, restart_o;
	logic [15:0] resp_len_i, window_len_o, max_packet_o;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, wbq, rx, st;
	logic [6:0] slave_addr_o, sa;
	logic [2:0] speed_mode_o, cur;
	int miscompares, tests_run, frames, restarts, c;

	i2c_link_if link_i ();
	i2c_reg_device i2c_reg_device_i (.clk_i(clk_i), .rst_i(rst_i),
		.ce_i(1'b1), .link(link_i), .busy_i(busy_i),
		.resp_ready_i(resp_ready_i), .resp_len_i(resp_len_i),
		.slave_addr_o(slave_addr_o), .speed_mode_o(speed_mode_o),
		.window_len_o(window_len_o), .max_packet_o(max_packet_o),
		.frame_written_o(frame_written_o), .restart_o(restart_o));
	i2c_reg_host i2c_reg_host_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.link(link_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.irq_o(irq_o));
	i2c_link_props i2c_link_props_i (.clk_i(clk_i), .rst_i(rst_i),
		.host_scl_o(link_i.host_scl_o), .host_scl_oe(link_i.host_scl_oe),
		.host_sda_o(link_i.host_sda_o), .host_sda_oe(link_i.host_sda_oe),
		.dev_scl_o(link_i.dev_scl_o), .dev_scl_oe(link_i.dev_scl_oe),
		.dev_sda_o(link_i.dev_sda_o), .dev_sda_oe(link_i.dev_sda_oe),
		.scl(link_i.scl), .sda(link_i.sda));

	// ------------------------------
	// Clock, pulse counters, watchdog
	// ------------------------------
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (frame_written_o === 1'b1) frames++;
		if (restart_o === 1'b1) restarts++;
	end
	initial begin
		repeat (99000) @(posedge clk_i);
		miscompares++;
		end_of_test;
	end

	// ------------------------------
	// Shared tasks
	// ------------------------------
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task end_of_test;
		if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// One classic cycle, held until ack is sampled
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do
			@(posedge clk_i);
		while (wb_ack_o !== 1'b1);
		wbq = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	// One link transfer, ended by the done interrupt
	task op(input logic [6:0] a, input logic [7:0] p, input logic r,
		input logic [2:0] n, input logic [31:0] tx);
		wb(1'b1, 8'h04, {16'h0, p, 1'b0, a});
		wb(1'b1, 8'h08, tx);
		wb(1'b1, 8'h00, {27'h0, n, r, 1'b1});
		while (irq_o !== 1'b1)
			@(posedge clk_i);
		wb(1'b0, 8'h10, 32'h0);
		st = wbq;
		wb(1'b1, 8'h10, 32'h3);
		wb(1'b0, 8'h0c, 32'h0);
		rx = wbq;
	endtask
	task wr(input logic [7:0] p, input logic [15:0] v);
		op(sa, p, 1'b0, 3'h2, {v, 16'h0});
	endtask
	task rd(input logic [7:0] p);
		op(sa, p, 1'b1, 3'h2, 32'h0);
		rx = {16'h0, rx[15:0]};
	endtask

	// ------------------------------
	// Scenarios
	// ------------------------------
	task status_test;
		op(sa, `REG_LINK_STATUS, 1'b1, 3'h4, 32'h0);
		chk("status busy", 32'h8e001234, rx);
		busy_i <= 1'b0;
		resp_ready_i <= 1'b1;
		resp_len_i <= 16'h0005;
		op(sa, `REG_LINK_STATUS, 1'b1, 3'h4, 32'h0);
		chk("status ready", 32'h4e000005, rx);
		op(sa, `REG_SPACING, 1'b1, 3'h4, 32'h0);
		chk("spacing", `UNSUPPORTED, rx);
		op(sa, `REG_RETRANSMIT, 1'b1, 3'h4, 32'h0);
		chk("retransmit", `UNSUPPORTED, rx);
		wb(1'b0, 8'h00, 32'h0);
		chk("unsupported flag", 32'h1, wbq[9]);
		wb(1'b0, 8'h18, 32'h0);
		chk("unmapped", 32'h0, wbq);
	endtask
	task window_test;
		wr(`REG_WINDOW_LEN, 16'h0010);
		chk("length held", 32'h20, window_len_o);
		rd(`REG_WINDOW_LEN);
		chk("length read", 32'h10, rx);
		chk("length active", 32'h10, window_len_o);
		chk("packet size", 32'h0b, max_packet_o);
		wr(`REG_WINDOW_LEN, 16'h0100);
		rd(`REG_WINDOW_LEN);
		chk("length too big", 32'h20, rx);
		wr(`REG_WINDOW_LEN, 16'h000f);
		rd(`REG_WINDOW_LEN);
		chk("length too small", 32'h20, rx);
		op(sa, `REG_DATA_WINDOW, 1'b0, 3'h4, 32'hc3a55a3c);
		op(sa, `REG_DATA_WINDOW, 1'b1, 3'h4, 32'h0);
		chk("window data", 32'hc3a55a3c, rx);
		chk("frame notice", 32'h1, frames);
	endtask
	task speed_test;
		cur = `SPEED_RST;
		for (c = 0; c < 8; c++) begin
			wr(`REG_SPEED, {13'h0, c[2:0]});
			if (c >= 1 && c <= 4) cur = c[2:0];
			rd(`REG_SPEED);
			chk("speed", {29'h0, cur}, rx);
			chk("speed port", {29'h0, cur}, speed_mode_o);
			op(sa, `REG_MAX_CLOCK, 1'b1, 3'h4, 32'h0);
			chk("clock limit", cur == `SPEED_SM ? `KHZ_SM :
				cur == `SPEED_FMP ? `KHZ_FMP : `KHZ_FM, rx);
		end
		wr(`REG_SPEED, 16'h8002);
		rd(`REG_SPEED);
		chk("persist flag", 32'h2, rx);
		wr(`REG_SPEED, 16'h0001);
		wr(`REG_RESTART, 16'h0000);
		rd(`REG_SPEED);
		chk("speed kept", 32'h2, rx);
		chk("restart pulse", 32'h1, restarts);
	endtask
	task address_test;
		wr(`REG_SLAVE_ADDR, 16'h0042);
		chk("address held", 32'h20, slave_addr_o);
		rd(`REG_SPEED);
		chk("old address", 32'h3, st);
		sa = 7'h42;
		rd(`REG_SLAVE_ADDR);
		chk("address read", 32'hffff, rx);
		chk("address port", 32'h42, slave_addr_o);
		wr(`REG_SLAVE_ADDR, 16'h8033);
		sa = 7'h33;
		wr(`REG_SLAVE_ADDR, 16'h0044);
		sa = 7'h44;
		wr(`REG_RESTART, 16'h0000);
		sa = 7'h33;
		rd(`REG_SPEED);
		chk("persist address", 32'h1, st);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		sa = `SLAVE_ADDR_RST;
		chk("reset address", 32'h20, slave_addr_o);
		chk("reset speed", 32'h3, speed_mode_o);
	endtask
	task irq_test;
		wb(1'b1, 8'h04, {16'h0, `REG_SPEED, 1'b0, sa});
		wb(1'b1, 8'h00, 32'h1);
		do
			wb(1'b0, 8'h00, 32'h0);
		while (wbq[8] !== 1'b0);
		chk("masked irq", 32'h0, irq_o);
		wb(1'b1, 8'h14, 32'h1);
		@(negedge clk_i);
		chk("unmasked irq", 32'h1, irq_o);
		@(posedge clk_i);
		wb(1'b1, 8'h10, 32'h1);
		@(negedge clk_i);
		chk("cleared irq", 32'h0, irq_o);
	endtask

	// ------------------------------
	// Main sequence
	// ------------------------------
	initial begin
		rst_i = 1'b1;
		{busy_i, resp_ready_i, wb_cyc_i, wb_stb_i, wb_we_i} = 5'h10;
		resp_len_i = 16'h1234;
		{wb_adr_i, wb_dat_i, wb_sel_i} = {40'h0, 4'hf};
		{miscompares, tests_run, frames, restarts} = 0;
		sa = `SLAVE_ADDR_RST;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		wb(1'b1, 8'h14, 32'h1);
		status_test;
		window_test;
		speed_test;
		address_test;
		irq_test;
		end_of_test;
	end
endmodule // testbench
